// ### hdl/metering_regs.svh
`ifndef METERING_REGS_SVH
`define METERING_REGS_SVH

// Register addresses on the host register port
`define CUR_PEAK_ADDR   16'hE500
`define VOLT_PEAK_ADDR  16'hE501
`define EVT_STAT_ADDR   16'hE502

// Peak register layout
`define PEAK_VAL_MSB    23
`define PEAK_PHASE_LSB  24
`define PEAK_PHASE_MSB  26
`define PEAK_RESET      32'h0000_0000

// First status register layout
`define ST_TOT_ACT_HF   0
`define ST_FUND_ACT_HF  1
`define ST_TOT_REA_HF   2
`define ST_FUND_REA_HF  3
`define ST_APP_HF       4
`define ST_LINE_DONE    5
`define ST_ACT_SIGN_LSB 6
`define ST_SUM_SIGN_1   9
`define ST_REA_SIGN_LSB 10
`define ST_SUM_SIGN_2   13
`define ST_PULSE_LSB    14
`define ST_COMPUTE_DONE 17
`define ST_SUM_SIGN_3   18
`define ST_USED_W       19
`define ST_RESET        19'h0_0000

// Sign register layout
`define SG_ACT_LSB      0
`define SG_SUM_1        3
`define SG_REA_LSB      4
`define SG_SUM_2        7
`define SG_SUM_3        8
`define SG_W            9

// Pulse mode select field width
`define PULSE_SEL_W     3

`endif

// ### hdl/metering_pkg.sv
package metering_pkg;

  // Phase that produced a peak; NONE loads no phase flag
  typedef enum logic [1:0] {
    PH_A,
    PH_B,
    PH_C,
    PH_NONE
  } phase_sel_t;

  typedef logic [2:0] phase_flags_t;

endpackage

// ### hdl/change_detect.sv
`timescale 1ns/100ps
module change_detect #(
  parameter int       W    = 1,
  parameter bit [0:0] IDLE = 1'b0
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         nrst,
  // Watched levels
  input  wire logic [W-1:0] level,
  // Events, valid in the cycle the level moves
  output logic      [W-1:0] changed,
  output logic      [W-1:0] fell
);

  logic [W-1:0] prev_ff;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prev_ff <= {W{IDLE}};
    end else begin
      prev_ff <= level;
    end
  end

  assign changed = prev_ff ^ level;
  assign fell    = prev_ff & ~level;

endmodule // change_detect

// ### hdl/peak_event_status.sv
`timescale 1ns/100ps
`include "metering_regs.svh"

// Behaviour
// R1 - Current peak register bits 23:0 hold current channel peak, reset zero.
// R2 - Exactly one current peak phase flag, bits 24-26, names phase A/B/C; none after reset or a PH_NONE load.
// R3 - Bits 31:27 of both peak registers always read zero.
// R4 - Voltage peak register bits 23:0 hold voltage channel peak, reset zero.
// R5 - Voltage peak phase flag bits 24-26 name phase A, B or C.
// R6 - Status bit 0 sets when bit 30 of any total active accumulator moves.
// R7 - Status bit 1 sets on bit 30 change of fundamental active accumulators.
// R8 - Status bit 2 sets on bit 30 change of total reactive accumulators.
// R9 - Status bit 3 sets on bit 30 change of fundamental reactive ones.
// R10 - Status bit 4 sets on bit 30 change of apparent energy accumulators.
// R11 - In line-cycle mode, status bit 5 sets when an integration ends.
// R12 - Status bits 6-8 set on active power sign change; mode bit 0 picks.
// R13 - Sign register bits 0-2 report current active power signs.
// R14 - Status bits 10-12 flag reactive sign change; signs in bits 4-6.
// R15 - Status bits 9, 13, 18 flag summed power sign; signs in bits 3,7,8.
// R16 - Status bits 14-16 set on falling edge of pulse outputs 1-3.
// R17 - Pulse edge flags set even when the pulse pin is disabled.
// R18 - Pulse mode fields 2:0, 5:3, 8:6 choose each pulse power type.
// R19 - Status bit 17 sets when each periodic computation round completes.
// R20 - Status register bits 31:19 always read zero.
// R21 - Flags stay set until written one; writing zero leaves them.
module peak_event_status #(
  parameter int PEAK_W      = 24,
  parameter int PULSE_TYPES = 8
) (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        nrst,
  // Host register port
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [15:0]                 reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  output logic      [31:0]                 reg_rdata,
  // Peak detectors
  input  wire logic                        current_peak_load,
  input  wire logic [PEAK_W-1:0]           current_peak_in,
  input  metering_pkg::phase_sel_t         current_peak_src,
  input  wire logic                        voltage_peak_load,
  input  wire logic [PEAK_W-1:0]           voltage_peak_in,
  input  metering_pkg::phase_sel_t         voltage_peak_src,
  // Bit 30 of each phase accumulator, phases A..C
  input  wire logic [2:0]                  tot_active_bit30,
  input  wire logic [2:0]                  fund_active_bit30,
  input  wire logic [2:0]                  tot_reactive_bit30,
  input  wire logic [2:0]                  fund_reactive_bit30,
  input  wire logic [2:0]                  apparent_bit30,
  // Line cycle accumulation
  input  wire logic                        line_cycle_mode,
  input  wire logic                        line_cycle_end,
  // Power signs, phases A..C, 1 means negative
  input  wire logic                        active_sign_source_select,
  input  wire logic                        reactive_sign_source_select,
  input  wire logic [2:0]                  tot_active_sign,
  input  wire logic [2:0]                  fund_active_sign,
  input  wire logic [2:0]                  tot_reactive_sign,
  input  wire logic [2:0]                  fund_reactive_sign,
  input  wire logic [2:0]                  sum_sign,
  output logic      [`SG_W-1:0]            power_sign_reg,
  // Pulse outputs, active low
  input  wire logic [PULSE_TYPES-1:0]      pulse_src_n,
  input  wire logic [3*`PULSE_SEL_W-1:0]   pulse_mode_reg,
  input  wire logic [2:0]                  pulse_disable,
  output logic      [2:0]                  pulse_out_n,
  // Periodic computation
  input  wire logic                        compute_cycle_done
);

  if (PEAK_W < 1 || PEAK_W > 24) begin : g_bad_peak_w
    $error("PEAK_W must lie between 1 and 24");
  end
  if (PULSE_TYPES < 2 || PULSE_TYPES > 8) begin : g_bad_types
    $error("PULSE_TYPES must lie between 2 and 8");
  end

  function automatic metering_pkg::phase_flags_t phase_onehot(
    input metering_pkg::phase_sel_t src
  );
    phase_onehot = 3'h0;
    unique case (src)
      metering_pkg::PH_A:    phase_onehot = 3'h1;
      metering_pkg::PH_B:    phase_onehot = 3'h2;
      metering_pkg::PH_C:    phase_onehot = 3'h4;
      metering_pkg::PH_NONE: phase_onehot = 3'h0;
    endcase
  endfunction

  function automatic logic [31:0] peak_word(
    input logic [PEAK_W-1:0]        val,
    input metering_pkg::phase_flags_t ph
  );
    peak_word = `PEAK_RESET;
    peak_word[PEAK_W-1:0] = val;
    peak_word[`PEAK_PHASE_MSB:`PEAK_PHASE_LSB] = ph;
  endfunction

  // Peak capture
  logic [PEAK_W-1:0]          cur_val_ff;
  metering_pkg::phase_flags_t cur_phase_ff;
  logic [PEAK_W-1:0]          volt_val_ff;
  metering_pkg::phase_flags_t volt_phase_ff;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cur_val_ff   <= '0;
      cur_phase_ff <= 3'h0;
    end else if (current_peak_load) begin
      cur_val_ff   <= current_peak_in;                  // R1
      cur_phase_ff <= phase_onehot(current_peak_src);   // R2
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      volt_val_ff   <= '0;
      volt_phase_ff <= 3'h0;
    end else if (voltage_peak_load) begin
      volt_val_ff   <= voltage_peak_in;                 // R4
      volt_phase_ff <= phase_onehot(voltage_peak_src);  // R5
    end
  end

  // Power sign selection and sign register
  logic [`SG_W-1:0] nxt_sign;
  logic [`SG_W-1:0] sign_ff;

  always_comb begin
    nxt_sign = '0;
    nxt_sign[`SG_ACT_LSB +: 3] = active_sign_source_select ?
                                 fund_active_sign : tot_active_sign; // R12 R13
    nxt_sign[`SG_REA_LSB +: 3] = reactive_sign_source_select ?
                                 fund_reactive_sign : tot_reactive_sign; // R14
    nxt_sign[`SG_SUM_1] = sum_sign[0];                               // R15
    nxt_sign[`SG_SUM_2] = sum_sign[1];
    nxt_sign[`SG_SUM_3] = sum_sign[2];
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sign_ff <= '0;
    end else begin
      sign_ff <= nxt_sign;
    end
  end

  assign power_sign_reg = sign_ff;

  // Pulse type selection; the flag sees the selected stream before gating
  logic [2:0] pulse_sel_n;
  logic [2:0] pulse_out_n_ff;

  for (genvar p = 0; p < 3; p++) begin : g_pulse
    logic [`PULSE_SEL_W-1:0] fld;
    assign fld = pulse_mode_reg[p*`PULSE_SEL_W +: `PULSE_SEL_W];
    // Codes beyond the implemented types park the stream idle high
    assign pulse_sel_n[p] = (32'(fld) < PULSE_TYPES) ?
                            pulse_src_n[fld] : 1'b1;              // R18
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pulse_out_n_ff <= 3'h7;
    end else begin
      pulse_out_n_ff <= pulse_sel_n | pulse_disable;
    end
  end

  assign pulse_out_n = pulse_out_n_ff;

  // Event detection: 15 accumulator bits, 9 signs, 3 pulses in one pass
  localparam int EV_W = 27;
  logic [EV_W-1:0] ev_level;
  logic [EV_W-1:0] ev_changed;
  logic [EV_W-1:0] ev_fell;

  assign ev_level = {pulse_sel_n, nxt_sign, apparent_bit30,
                     fund_reactive_bit30, tot_reactive_bit30,
                     fund_active_bit30, tot_active_bit30};

  // Idle high suits the pulse streams; accumulators and signs start at zero
  // and their first real movement still counts as a change.
  change_detect #(.W(24), .IDLE(1'b0)) u_level_det (
    .clock   (clock),
    .nrst    (nrst),
    .level   (ev_level[23:0]),
    .changed (ev_changed[23:0]),
    .fell    ()
  );

  change_detect #(.W(3), .IDLE(1'b1)) u_pulse_det (
    .clock   (clock),
    .nrst    (nrst),
    .level   (ev_level[26:24]),
    .changed (),
    .fell    (ev_fell[26:24])
  );

  assign ev_changed[26:24] = 3'h0;
  assign ev_fell[23:0]     = 24'h00_0000;

  // Status event vector
  logic [`ST_USED_W-1:0] ev_set;
  logic [`SG_W-1:0]      sg_ch;

  assign sg_ch = ev_changed[23:15];

  always_comb begin
    ev_set = `ST_RESET;
    ev_set[`ST_TOT_ACT_HF]  = |ev_changed[2:0];                 // R6
    ev_set[`ST_FUND_ACT_HF] = |ev_changed[5:3];                 // R7
    ev_set[`ST_TOT_REA_HF]  = |ev_changed[8:6];                 // R8
    ev_set[`ST_FUND_REA_HF] = |ev_changed[11:9];                // R9
    ev_set[`ST_APP_HF]      = |ev_changed[14:12];               // R10
    ev_set[`ST_LINE_DONE]   = line_cycle_mode & line_cycle_end; // R11
    ev_set[`ST_ACT_SIGN_LSB +: 3] = sg_ch[`SG_ACT_LSB +: 3];    // R12
    ev_set[`ST_REA_SIGN_LSB +: 3] = sg_ch[`SG_REA_LSB +: 3];    // R14
    ev_set[`ST_SUM_SIGN_1]  = sg_ch[`SG_SUM_1];                 // R15
    ev_set[`ST_SUM_SIGN_2]  = sg_ch[`SG_SUM_2];
    ev_set[`ST_SUM_SIGN_3]  = sg_ch[`SG_SUM_3];
    ev_set[`ST_PULSE_LSB +: 3] = ev_fell[26:24];                // R16 R17
    ev_set[`ST_COMPUTE_DONE] = compute_cycle_done;              // R19
  end

  // Status register, write one to clear, a new event beats the clear
  logic [`ST_USED_W-1:0] status_ff;
  logic [`ST_USED_W-1:0] clr_mask;

  assign clr_mask = (reg_wr && reg_addr == `EVT_STAT_ADDR) ?
                    reg_wdata[`ST_USED_W-1:0] : `ST_RESET;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      status_ff <= `ST_RESET;
    end else begin
      status_ff <= (status_ff & ~clr_mask) | ev_set;            // R21
    end
  end

  // Read path; peak registers ignore writes
  logic [31:0] nxt_rdata;
  logic [31:0] rdata_ff;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (reg_addr)
      `CUR_PEAK_ADDR:  nxt_rdata = peak_word(cur_val_ff, cur_phase_ff); // R3
      `VOLT_PEAK_ADDR: nxt_rdata = peak_word(volt_val_ff, volt_phase_ff);
      `EVT_STAT_ADDR:  nxt_rdata[`ST_USED_W-1:0] = status_ff;          // R20
      default:         nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  cur_peak_load_a: assert property (                                // R1
    current_peak_load |=> cur_val_ff == $past(current_peak_in)
  ) else $error("current peak value not captured");

  cur_phase_onehot_a: assert property (                             // R2
    current_peak_load && current_peak_src != metering_pkg::PH_NONE
    |=> $onehot(cur_phase_ff) && cur_phase_ff[$past(current_peak_src)]
  ) else $error("current peak phase flag wrong");

  peak_top_zero_a: assert property (                                // R3
    reg_rd && (reg_addr == `CUR_PEAK_ADDR || reg_addr == `VOLT_PEAK_ADDR)
    |=> reg_rdata[31:27] == 5'h00
  ) else $error("peak register top bits not zero");

  volt_peak_load_a: assert property (                               // R4
    voltage_peak_load |=> volt_val_ff == $past(voltage_peak_in)
  ) else $error("voltage peak value not captured");

  volt_phase_a: assert property (                                   // R5
    voltage_peak_load
    |=> volt_phase_ff == ($past(voltage_peak_src) == metering_pkg::PH_NONE ?
                          3'h0 : 3'(1 << $past(voltage_peak_src)))
  ) else $error("voltage peak phase flag wrong");

  acc_half_full_a: assert property (                                // R6
    $changed(tot_active_bit30) |=> status_ff[`ST_TOT_ACT_HF]
  ) else $error("accumulator bit 30 change not flagged");

  line_cycle_off_a: assert property (                               // R11
    !line_cycle_mode && !status_ff[`ST_LINE_DONE]
    |=> !status_ff[`ST_LINE_DONE]
  ) else $error("line cycle flag set outside its mode");

  act_sign_flag_a: assert property (                                // R12
    $changed(sign_ff[`SG_ACT_LSB]) |-> status_ff[`ST_ACT_SIGN_LSB]
  ) else $error("active sign change not flagged");

  pulse_edge_flag_a: assert property (                              // R17
    $fell(pulse_sel_n[0]) && pulse_disable[0]
    |=> status_ff[`ST_PULSE_LSB] && pulse_out_n[0]
  ) else $error("disabled pulse edge not flagged");

  status_rsvd_a: assert property (                                  // R20
    reg_rd && reg_addr == `EVT_STAT_ADDR |=> reg_rdata[31:19] == 13'h0000
  ) else $error("status reserved bits not zero");

  flag_sticky_a: assert property (                                  // R21
    status_ff[`ST_COMPUTE_DONE] && !clr_mask[`ST_COMPUTE_DONE]
    |=> status_ff[`ST_COMPUTE_DONE]
  ) else $error("status flag lost without a clear");

  set_beats_clear_a: assert property (                              // R21
    compute_cycle_done && clr_mask[`ST_COMPUTE_DONE]
    |=> status_ff[`ST_COMPUTE_DONE]
  ) else $error("clear won over a new event");

  peak_hold_a: assert property (                                    // R1
    !current_peak_load |=> $stable(cur_val_ff) && $stable(cur_phase_ff)
  ) else $error("current peak changed without a load");

  pulse_flag_a: assert property (                                   // R16
    $fell(pulse_sel_n[1]) |=> status_ff[`ST_PULSE_LSB + 1]
  ) else $error("pulse edge not flagged");

  compute_flag_a: assert property (                                 // R19
    compute_cycle_done |=> status_ff[`ST_COMPUTE_DONE]
  ) else $error("computation round not flagged");

  line_cycle_set_a: assert property (                               // R11
    line_cycle_mode && line_cycle_end |=> status_ff[`ST_LINE_DONE]
  ) else $error("line cycle end not flagged");

  clear_works_a: assert property (                                  // R21
    clr_mask[`ST_APP_HF] && !ev_set[`ST_APP_HF]
    |=> !status_ff[`ST_APP_HF]
  ) else $error("written one did not clear the flag");

endmodule // peak_event_status

// ### verif/metering_peak_and_event_status_tb_top.sv
`timescale 1ns/100ps
`include "metering_regs.svh"

module metering_peak_and_event_status_tb_top;
  logic                      clock;
  logic                      nrst;
  logic                      reg_wr;
  logic                      reg_rd;
  logic [15:0]               reg_addr;
  logic [31:0]               reg_wdata;
  logic [31:0]               reg_rdata;
  logic                      cpl;
  logic                      vpl;
  logic [23:0]               cpi;
  logic [23:0]               vpi;
  metering_pkg::phase_sel_t  cps;
  metering_pkg::phase_sel_t  vps;
  logic [14:0]               b30;
  logic                      lcm;
  logic                      lce;
  logic                      asel;
  logic                      rsel;
  logic [2:0]                ta, fa, tr, fr, ss;
  logic [8:0]                psr;
  logic [7:0]                psrc;
  logic [8:0]                pmode;
  logic [2:0]                pdis;
  logic [2:0]                pout;
  logic                      ccd;
  int                        fail_count;
  int                        cmp_count;
  int                        cycles;
  logic [31:0]               exp_st;
  logic [31:0]               d;
  logic [23:0]               v1;
  logic [23:0]               v2;
  int                        sb [3] = '{9, 13, 18};
  int                        c;

  peak_event_status dut (
    .clock(clock), .nrst(nrst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .current_peak_load(cpl), .current_peak_in(cpi), .current_peak_src(cps),
    .voltage_peak_load(vpl), .voltage_peak_in(vpi), .voltage_peak_src(vps),
    .tot_active_bit30(b30[2:0]), .fund_active_bit30(b30[5:3]),
    .tot_reactive_bit30(b30[8:6]), .fund_reactive_bit30(b30[11:9]),
    .apparent_bit30(b30[14:12]),
    .line_cycle_mode(lcm), .line_cycle_end(lce),
    .active_sign_source_select(asel), .reactive_sign_source_select(rsel),
    .tot_active_sign(ta), .fund_active_sign(fa),
    .tot_reactive_sign(tr), .fund_reactive_sign(fr), .sum_sign(ss),
    .power_sign_reg(psr),
    .pulse_src_n(psrc), .pulse_mode_reg(pmode), .pulse_disable(pdis),
    .pulse_out_n(pout), .compute_cycle_done(ccd)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic close_out();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Generous ceiling; the whole sequence needs about 750 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      fail_count++;
      $display("[ERR] %0t run did not finish", $time);
      close_out();
    end
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t register word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk9(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t sign word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t pulse outputs %b expected %b", $time, got, exp);
    end
  endtask

  task automatic step();
    @(negedge clock);
  endtask

  // Bus tasks start one falling edge later so a strobe never toggles twice
  task automatic rd(input logic [15:0] a, output logic [31:0] q);
    step();
    reg_rd = 1'b1;
    reg_addr = a;
    step();
    reg_rd = 1'b0;
    q = reg_rdata;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] q);
    step();
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = q;
    step();
    reg_wr = 1'b0;
  endtask

  // Compare with the model, show a zero write keeps flags, then clear all
  task automatic chk_status();
    logic [31:0] q;
    rd(`EVT_STAT_ADDR, q);
    chk32(q, exp_st);
    wr(`EVT_STAT_ADDR, 32'h0000_0000);
    rd(`EVT_STAT_ADDR, q);
    chk32(q, exp_st);
    wr(`EVT_STAT_ADDR, 32'hFFFF_FFFF);
    exp_st = 32'h0000_0000;
    rd(`EVT_STAT_ADDR, q);
    chk32(q, exp_st);
  endtask

  function automatic logic [8:0] exp_sign();
    return {ss[2], ss[1], rsel ? fr : tr, ss[0], asel ? fa : ta};
  endfunction

  function automatic logic [31:0] peak_word(input logic [23:0] v,
                                            input int ph);
    return {5'h00, (ph < 3) ? 3'(1 << ph) : 3'h0, v};
  endfunction

  initial begin
    {reg_wr, reg_rd, cpl, vpl, lcm, lce, asel, rsel, ccd} = '0;
    {reg_addr, reg_wdata, cpi, vpi, b30, ta, fa, tr, fr, ss} = '0;
    {pmode, pdis, fail_count, cmp_count, cycles, exp_st} = '0;
    cps = metering_pkg::PH_NONE;
    vps = metering_pkg::PH_NONE;
    psrc = 8'hFF;
    nrst = 1'b0;
    void'($urandom(90));
    repeat (20) step();
    nrst = 1'b1;
    rd(`CUR_PEAK_ADDR, d);
    chk32(d, 32'h0000_0000);
    rd(`VOLT_PEAK_ADDR, d);
    chk32(d, 32'h0000_0000);
    chk_status();
    rd(16'hE503, d);
    chk32(d, 32'h0000_0000);
    for (int ph = 0; ph < 4; ph++) begin
      step();
      v1 = 24'($urandom);
      v2 = 24'($urandom);
      {cpl, vpl, cpi, vpi} = {1'b1, 1'b1, v1, v2};
      cps = metering_pkg::phase_sel_t'(ph);
      vps = metering_pkg::phase_sel_t'(3 - ph);
      step();
      {cpl, vpl} = 2'b00;
      rd(`CUR_PEAK_ADDR, d);
      chk32(d, peak_word(v1, ph));
      wr(`VOLT_PEAK_ADDR, 32'hFFFF_FFFF);
      rd(`VOLT_PEAK_ADDR, d);
      chk32(d, peak_word(v2, 3 - ph));
    end
    for (int g = 0; g < 5; g++) begin
      for (int i = 0; i < 6; i++) begin
        step();
        b30[g * 3 + i % 3] = ~b30[g * 3 + i % 3];
        exp_st[g] = 1'b1;
        chk_status();
      end
    end
    step();
    lce = 1'b1;
    step();
    lce = 1'b0;
    chk_status();
    lcm = 1'b1;
    lce = 1'b1;
    step();
    lce = 1'b0;
    exp_st[5] = 1'b1;
    chk_status();
    for (int sel = 0; sel < 2; sel++) begin
      for (int p = 0; p < 3; p++) begin
        step();
        asel = sel[0];
        rsel = sel[0];
        step();
        if (sel == 1) {fa[p], fr[p]} = 2'b11;
        else {ta[p], tr[p]} = 2'b11;
        ss[p] = 1'b1;
        exp_st = (32'h1 << (6 + p)) | (32'h1 << (10 + p)) | (32'h1 << sb[p]);
        step();
        chk9(psr, exp_sign());
        chk_status();
        // The unselected source must not raise a flag
        if (sel == 1) {ta[p], tr[p]} = 2'b11;
        else {fa[p], fr[p]} = 2'b11;
        step();
        chk9(psr, exp_sign());
        chk_status();
        {ta[p], fa[p], tr[p], fr[p], ss[p]} = '0;
        exp_st = (32'h1 << (6 + p)) | (32'h1 << (10 + p)) | (32'h1 << sb[p]);
        step();
        chk9(psr, exp_sign());
        chk_status();
      end
    end
    for (int i = 0; i < 6; i++) begin
      c = $urandom % 8;
      step();
      pmode = {3{3'((c + 1) % 8)}};
      pmode[(i % 3) * 3 +: 3] = 3'(c);
      pdis = 3'($urandom);
      // Each output is seen both disabled and enabled
      pdis[i % 3] = i[0];
      step();
      psrc[c] = 1'b0;
      step();
      chk3(pout, ~(~pdis & 3'(1 << (i % 3))));
      psrc[c] = 1'b1;
      exp_st = 32'h1 << (14 + i % 3);
      step();
      chk3(pout, 3'b111);
      chk_status();
    end
    step();
    ccd = 1'b1;
    step();
    ccd = 1'b0;
    exp_st[17] = 1'b1;
    chk_status();
    // An event in the very cycle of its clear must survive the clear
    step();
    {reg_wr, reg_addr, reg_wdata} = {1'b1, `EVT_STAT_ADDR, 32'hFFFF_FFFF};
    ccd = 1'b1;
    step();
    {reg_wr, ccd} = 2'b00;
    exp_st[17] = 1'b1;
    chk_status();
    // A second reset in mid-run must drop a pending flag
    ccd = 1'b1;
    step();
    ccd = 1'b0;
    nrst = 1'b0;
    repeat (2) step();
    nrst = 1'b1;
    rd(`EVT_STAT_ADDR, d);
    chk32(d, 32'h0000_0000);
    close_out();
  end
endmodule // metering_peak_and_event_status_tb_top
